/* core/tsls_pkg.sv */
// Shared constants and types of the time-slot loopback switch.
// Assumes a single 100 MHz clock domain and one slot step per clock.
package tsls_pkg;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int SLOT_W = 4; // Slot index width, 16 slots a frame
  localparam int BYTE_W = 8; // One slot carries one byte

  // ****************************************************************
  // Pointer and connection entry layout
  // ****************************************************************
  localparam int PTR_UD_BIT = 7; // Direction bit of a pointer
  localparam int ENT_W = 9; // {code[3:0], ud, slot[3:0]}
  localparam int ENT_CODE_LSB = 5; // Channel code field position
  localparam int ENT_UD_BIT = 4; // Direction bit inside an entry
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0; // No connection
  localparam logic [3:0] CODE_FULL_SLOT = 4'h1; // Whole 64 kbit/s slot

  // ****************************************************************
  // Memory operation codes
  // ****************************************************************
  localparam logic [7:0] OP_TRISTATE = 8'h60; // Tristate field access
  localparam logic [3:0] OP_CM_HI = 4'h7; // Upper nibble of CM write

  // ****************************************************************
  // Host command selectors and buffer
  // ****************************************************************
  localparam logic [1:0] SEL_DATA = 2'h0; // Load data register
  localparam logic [1:0] SEL_ADDR = 2'h1; // Load address register
  localparam logic [1:0] SEL_CTRL = 2'h2; // Load control, start access
  localparam int BUF_DEPTH = 2; // Command buffer entries
  localparam logic [7:0] REG_RESET = 8'h00; // Reset of host registers

  // Command executor states
  typedef enum logic {EX_IDLE, EX_APPLY} tsls_exec_t;

endpackage

/* core/tsls_mem.sv */
// Small word memory with one write port and a registered read port.
// Assumes synchronous use on clk; contents clear under reset.
`timescale 1ns/1ps
module tsls_mem
  import tsls_pkg::*;
#(
  parameter int W = 8,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port, data one cycle after address
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem_ff [2**AW]; // Storage words

  // ****************************************************************
  // Storage and read register
  // ****************************************************************
  // Clearing on reset keeps every entry unassigned and high impedance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_ff[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      // Read before write: same-cycle write shows on the next read
      rd_data <= mem_ff[rd_addr];
    end
  end

endmodule

/* core/tsls_loopback_switch.sv */
// Time-slot switch core with loops over the opposite interface.
// Assumes serial data already framed into one byte per slot per clock,
// and a host on the same clock issuing data/address/control commands.
`timescale 1ns/1ps
module tsls_loopback_switch
  import tsls_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial interfaces, receive bytes from pins
  input wire logic [7:0] pcm_rx_data,
  input wire logic [7:0] cfi_rx_data,
  // Serial interfaces, transmit bytes and enables
  output logic [7:0] pcm_tx_data,
  output logic [7:0] pcm_tx_oe,
  output logic [7:0] cfi_tx_data,
  output logic cfi_tx_oe,
  output logic [3:0] frame_slot,
  // Host command stream
  input wire logic host_valid,
  input wire logic [1:0] host_sel,
  input wire logic [7:0] host_wdata,
  output logic host_ready,
  output logic cmd_error
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] pcm_s1_ff, pcm_s2_ff, cfi_s1_ff, cfi_s2_ff; // Synchronisers
  logic [SLOT_W-1:0] cnt_ff, nxt_cnt; // Slot of synced data
  logic [7:0] p1_cfi_ff, nxt_p1_cfi, p2_cfi_ff, nxt_p2_cfi; // Upstream bytes
  logic [ENT_W-1:0] p2_us_ff, nxt_p2_us; // Upstream entry at stage 2
  logic [ENT_W-1:0] p2_ds_ff, nxt_p2_ds; // Downstream entry at stage 2
  logic [7:0] pcm_tx_ff, nxt_pcm_tx, pcm_oe_ff, nxt_pcm_oe;
  logic [7:0] cfi_tx_ff, nxt_cfi_tx;
  logic cfi_oe_ff, nxt_cfi_oe;
  logic [ENT_W-1:0] us_cm_rd, ds_cm_rd; // Connection entries, stage 1
  logic [7:0] ds_dm_rd, us_a_rd, us_b_rd, ts_rd; // Memory read data
  logic [7:0] ds_val; // Internal downstream serial output byte
  logic us_we; // Upstream data memory write
  logic [SLOT_W-1:0] us_waddr;
  logic [7:0] us_wdata;
  // Host side
  logic [9:0] buf_ff [BUF_DEPTH]; // {sel, data} entries
  logic [9:0] nxt_buf [BUF_DEPTH];
  logic [1:0] buf_cnt_ff, nxt_buf_cnt;
  logic buf_head_ff, nxt_buf_head;
  logic rdy_ff, nxt_rdy, err_ff, nxt_err;
  logic [7:0] data_reg_ff, nxt_data_reg, addr_reg_ff, nxt_addr_reg;
  logic [7:0] ctrl_reg_ff, nxt_ctrl_reg;
  tsls_exec_t ex_ff, nxt_ex;
  logic push, pop;
  logic ts_we, us_cm_we, ds_cm_we;
  logic [7:0] ts_wdata;
  logic [ENT_W-1:0] cm_wdata;

  // Spread four pair enables onto eight bit enables
  function automatic logic [7:0] pair_oe(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++) begin
      r[2*i] = d[i];
      r[2*i+1] = d[i];
    end
    return r;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pin bytes pass two flops before the switch reads them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcm_s1_ff <= 8'h00;
      pcm_s2_ff <= 8'h00;
      cfi_s1_ff <= 8'h00;
      cfi_s2_ff <= 8'h00;
    end else begin
      pcm_s1_ff <= pcm_rx_data;
      pcm_s2_ff <= pcm_s1_ff;
      cfi_s1_ff <= cfi_rx_data;
      cfi_s2_ff <= cfi_s1_ff;
    end
  end

  // ****************************************************************
  // Memories
  // ****************************************************************
  // Downstream data memory, written with received PCM bytes by slot
  tsls_mem #(.W(8), .AW(SLOT_W)) u_ds_dm (
    .clk(clk), .rst(rst), .wr_en(1'b1), .wr_addr(cnt_ff),
    .wr_data(pcm_s2_ff), .rd_addr(ds_cm_rd[3:0]), .rd_data(ds_dm_rd));
  // Upstream data memory, copy read by the PCM transmitter
  tsls_mem #(.W(8), .AW(SLOT_W)) u_us_dm_a (
    .clk(clk), .rst(rst), .wr_en(us_we), .wr_addr(us_waddr),
    .wr_data(us_wdata), .rd_addr(cnt_ff), .rd_data(us_a_rd));
  // Second copy gives the downstream return path its own read port
  tsls_mem #(.W(8), .AW(SLOT_W)) u_us_dm_b (
    .clk(clk), .rst(rst), .wr_en(us_we), .wr_addr(us_waddr),
    .wr_data(us_wdata), .rd_addr(ds_cm_rd[3:0]), .rd_data(us_b_rd));
  // Connection memories indexed by line-card slot
  tsls_mem #(.W(ENT_W), .AW(SLOT_W)) u_us_cm (
    .clk(clk), .rst(rst), .wr_en(us_cm_we), .wr_addr(addr_reg_ff[3:0]),
    .wr_data(cm_wdata), .rd_addr(cnt_ff), .rd_data(us_cm_rd));
  tsls_mem #(.W(ENT_W), .AW(SLOT_W)) u_ds_cm (
    .clk(clk), .rst(rst), .wr_en(ds_cm_we), .wr_addr(addr_reg_ff[3:0]),
    .wr_data(cm_wdata), .rd_addr(cnt_ff), .rd_data(ds_cm_rd));
  // Tristate fields per PCM transmit slot, reset is all high impedance
  tsls_mem #(.W(8), .AW(SLOT_W)) u_ts (
    .clk(clk), .rst(rst), .wr_en(ts_we), .wr_addr(addr_reg_ff[3:0]),
    .wr_data(ts_wdata), .rd_addr(cnt_ff), .rd_data(ts_rd));

  // ****************************************************************
  // Switching pipeline
  // ****************************************************************
  // Stage 0 reads entries, stage 1 reads data, stage 2 writes/sends
  always_comb begin
    nxt_cnt = cnt_ff + 4'h1;
    nxt_p1_cfi = cfi_s2_ff;
    nxt_p2_cfi = p1_cfi_ff;
    nxt_p2_us = us_cm_rd;
    nxt_p2_ds = ds_cm_rd;
    // Borrowed PCM slot drives only where its field says low Z
    nxt_pcm_tx = us_a_rd;
    nxt_pcm_oe = ts_rd;
    // U/D=1 returns bytes stored upstream, not from the PCM line
    ds_val = p2_ds_ff[ENT_UD_BIT] ? us_b_rd : ds_dm_rd;
    // Full byte moves; code zero keeps the output disabled
    nxt_cfi_tx = ds_val;
    nxt_cfi_oe = p2_ds_ff[8:5] != CODE_UNASSIGNED;
    // Leading zero takes the internal downstream byte as input
    us_wdata = p2_us_ff[ENT_UD_BIT] ? p2_cfi_ff : ds_val;
    // Either way the pointer names an upstream PCM slot
    us_waddr = p2_us_ff[3:0];
    us_we = p2_us_ff[8:5] != CODE_UNASSIGNED;
  end

  // Registers of the pipeline; outputs come straight from these
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      p1_cfi_ff <= 8'h00;
      p2_cfi_ff <= 8'h00;
      p2_us_ff <= '0;
      p2_ds_ff <= '0;
      pcm_tx_ff <= 8'h00;
      pcm_oe_ff <= 8'h00;
      cfi_tx_ff <= 8'h00;
      cfi_oe_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      p1_cfi_ff <= nxt_p1_cfi;
      p2_cfi_ff <= nxt_p2_cfi;
      p2_us_ff <= nxt_p2_us;
      p2_ds_ff <= nxt_p2_ds;
      pcm_tx_ff <= nxt_pcm_tx;
      pcm_oe_ff <= nxt_pcm_oe;
      cfi_tx_ff <= nxt_cfi_tx;
      cfi_oe_ff <= nxt_cfi_oe;
    end
  end

  // ****************************************************************
  // Host command buffer and executor
  // ****************************************************************
  // Two entries absorb a control word while the executor applies it
  always_comb begin
    push = host_valid && rdy_ff;
    pop = (buf_cnt_ff != 2'h0) && (ex_ff == EX_IDLE);
    nxt_buf = buf_ff;
    if (push) begin
      // Tail sits one past the head whenever one entry is queued, even
      // when that entry leaves in this cycle and the head moves onto it
      nxt_buf[buf_head_ff ^ buf_cnt_ff[0]] = {host_sel, host_wdata};
    end
    nxt_buf_cnt = buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    nxt_buf_head = pop ? ~buf_head_ff : buf_head_ff;
    nxt_rdy = nxt_buf_cnt != 2'(BUF_DEPTH);
    nxt_data_reg = data_reg_ff;
    nxt_addr_reg = addr_reg_ff;
    nxt_ctrl_reg = ctrl_reg_ff;
    nxt_ex = EX_IDLE;
    nxt_err = err_ff;
    if (pop) begin
      // Data and address only load; control starts the access
      if (buf_ff[buf_head_ff][9:8] == SEL_DATA) begin
        nxt_data_reg = buf_ff[buf_head_ff][7:0];
      end else if (buf_ff[buf_head_ff][9:8] == SEL_ADDR) begin
        nxt_addr_reg = buf_ff[buf_head_ff][7:0];
      end else if (buf_ff[buf_head_ff][9:8] == SEL_CTRL) begin
        nxt_ctrl_reg = buf_ff[buf_head_ff][7:0];
        nxt_ex = EX_APPLY;
      end else begin
        nxt_err = 1'b1;
      end
    end
    // Access uses the data and address loaded before it
    ts_we = (ex_ff == EX_APPLY) && (ctrl_reg_ff == OP_TRISTATE);
    ts_wdata = pair_oe(data_reg_ff);
    cm_wdata = {ctrl_reg_ff[3:0], data_reg_ff[PTR_UD_BIT], data_reg_ff[3:0]};
    us_cm_we = (ex_ff == EX_APPLY) && (ctrl_reg_ff[7:4] == OP_CM_HI)
      && addr_reg_ff[PTR_UD_BIT];
    ds_cm_we = (ex_ff == EX_APPLY) && (ctrl_reg_ff[7:4] == OP_CM_HI)
      && !addr_reg_ff[PTR_UD_BIT];
    if ((ex_ff == EX_APPLY) && !ts_we && (ctrl_reg_ff[7:4] != OP_CM_HI)) begin
      nxt_err = 1'b1; // Unknown operation code is ignored and flagged
    end
  end

  // Host registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      buf_cnt_ff <= 2'h0;
      buf_head_ff <= 1'b0;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      data_reg_ff <= REG_RESET;
      addr_reg_ff <= REG_RESET;
      ctrl_reg_ff <= REG_RESET;
      ex_ff <= EX_IDLE;
    end else begin
      buf_ff <= nxt_buf;
      buf_cnt_ff <= nxt_buf_cnt;
      buf_head_ff <= nxt_buf_head;
      rdy_ff <= nxt_rdy;
      err_ff <= nxt_err;
      data_reg_ff <= nxt_data_reg;
      addr_reg_ff <= nxt_addr_reg;
      ctrl_reg_ff <= nxt_ctrl_reg;
      ex_ff <= nxt_ex;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pcm_tx_data = pcm_tx_ff;
  assign pcm_tx_oe = pcm_oe_ff;
  assign cfi_tx_data = cfi_tx_ff;
  assign cfi_tx_oe = cfi_oe_ff;
  assign frame_slot = cnt_ff;
  assign host_ready = rdy_ff;
  assign cmd_error = err_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cfi_code_off: assert property (
    (p2_ds_ff[8:5] == CODE_UNASSIGNED) |=> !cfi_tx_oe)
    else $error("downstream output driven on unassigned code");
  a_return_path: assert property (
    (p2_ds_ff[ENT_UD_BIT] && p2_ds_ff[8:5] != CODE_UNASSIGNED)
    |=> cfi_tx_oe && (cfi_tx_data == $past(us_b_rd)))
    else $error("return byte not from upstream memory");
  // Checked on the stored word, so a wrong mux or port shows up
  a_loop_source: assert property (
    (us_we && !p2_us_ff[ENT_UD_BIT])
    |=> (u_us_dm_a.mem_ff[$past(us_waddr)] == $past(ds_val)))
    else $error("loop input not from internal output");
  a_loop_dest: assert property (
    (us_we && !p2_us_ff[ENT_UD_BIT])
    |=> (u_us_dm_b.mem_ff[$past(p2_us_ff[3:0])] == $past(ds_val)))
    else $error("upstream write slot wrong");
  a_ts_full: assert property (
    (ts_we && data_reg_ff == 8'h0F) |-> (ts_wdata == 8'hFF))
    else $error("tristate 0F not all low Z");
  a_cm_write: assert property (
    (pop && buf_ff[buf_head_ff] == {SEL_CTRL, 8'h71})
    |=> (us_cm_we || ds_cm_we) && (cm_wdata[8:5] == 4'h1))
    else $error("control 71h did not write entry");
  a_exec_order: assert property (
    (pop && buf_ff[buf_head_ff][9:8] == SEL_CTRL)
    |=> (ex_ff == EX_APPLY) ##1 (ex_ff == EX_IDLE))
    else $error("control access not applied once");
  a_pcm_hiz: assert property (
    (ts_rd == 8'h00) |=> (pcm_tx_oe == 8'h00))
    else $error("PCM slot driven while high Z");
  a_buf_full: assert property (
    (buf_cnt_ff == 2'h2) |-> !host_ready)
    else $error("ready while buffer full");

endmodule

/* testbench/tsls_line_model.sv */
// Line side model: PCM highway and line card bytes, one per slot.
// Assumes the switch shows the slot index on frame_slot each clock.
`timescale 1ns/1ps
module tsls_line_model
  import tsls_pkg::*;
(
  // Clock and slot position
  input wire logic clk,
  input wire logic [3:0] frame_slot,
  // Bytes toward the switch
  output logic [7:0] pcm_rx_data,
  output logic [7:0] cfi_rx_data
);
  // Slot whose byte is due on the pins now
  logic [3:0] ahead;
  always_comb ahead = frame_slot + 4'h2;

  // Each byte names its side and slot, so a misrouted byte shows
  initial begin
    pcm_rx_data = 8'h00;
    cfi_rx_data = 8'h00;
    forever begin
      @(posedge clk);
      #1;
      pcm_rx_data = {4'hA, ahead};
      cfi_rx_data = {4'h5, ahead};
    end
  end
endmodule

/* testbench/test_timeslot_loopback_switch.sv */
// Self-checking bench for the loopback switch core.
// Assumes the line model drives slot bytes; host commands come from here.
`timescale 1ns/1ps
module test_timeslot_loopback_switch
  import tsls_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, rst, host_valid, host_ready, cmd_error, cfi_tx_oe;
  logic [1:0] host_sel;
  logic [7:0] host_wdata, pcm_rx_data, cfi_rx_data;
  logic [7:0] pcm_tx_data, pcm_tx_oe, cfi_tx_data;
  logic [3:0] frame_slot;
  int errors = 0;
  int comparisons = 0;
  int stalls = 0; // Edges where a command waited
  int cycles = 0; // Hang guard

  tsls_loopback_switch i_tsls_loopback_switch (
    .clk(clk), .rst(rst), .pcm_rx_data(pcm_rx_data),
    .cfi_rx_data(cfi_rx_data), .pcm_tx_data(pcm_tx_data),
    .pcm_tx_oe(pcm_tx_oe), .cfi_tx_data(cfi_tx_data),
    .cfi_tx_oe(cfi_tx_oe), .frame_slot(frame_slot),
    .host_valid(host_valid), .host_sel(host_sel),
    .host_wdata(host_wdata), .host_ready(host_ready),
    .cmd_error(cmd_error));

  tsls_line_model i_tsls_line_model (
    .clk(clk), .frame_slot(frame_slot),
    .pcm_rx_data(pcm_rx_data), .cfi_rx_data(cfi_rx_data));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Closing report, the only exit
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare one byte
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold one command until the edge that samples ready high
  task automatic send(input logic [1:0] sel, input logic [7:0] d);
    logic r;
    int n;
    host_valid = 1'b1;
    host_sel = sel;
    host_wdata = d;
    n = 0;
    do begin
      @(negedge clk);
      r = host_ready;
      @(posedge clk);
      #1;
      n++;
      if (r !== 1'b1) stalls++;
    end while (r !== 1'b1 && n < 20);
    chk("host_ready", 8'h01, {7'h0, r});
  endtask

  // Data, address, control, then release
  task automatic prog(input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] c);
    // Start just after a rising edge, whatever the caller left
    @(posedge clk);
    #1;
    send(SEL_DATA, d);
    send(SEL_ADDR, a);
    send(SEL_CTRL, c);
    host_valid = 1'b0;
    // Let one edge pass so a following call does not retoggle valid
    @(posedge clk);
    #1;
  endtask

  // Let the command land and a full frame pass
  task automatic settle();
    repeat (40) @(posedge clk);
    #1;
  endtask

  // Stop in the cycle whose outputs belong to slot s
  task automatic look(input logic [3:0] s, input logic [3:0] lag);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame_slot !== s + lag && n < 40);
    chk("frame_slot", {4'h0, 4'(s + lag)}, {4'h0, frame_slot});
  endtask

  // ****************************************************************
  // Clock, hang guard, sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    rst = 1'b1;
    host_valid = 1'b0;
    host_sel = SEL_DATA;
    host_wdata = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    @(negedge clk);
    chk("pcm_tx_oe", 8'h00, pcm_tx_oe);
    chk("cfi_tx_oe", 8'h00, {7'h0, cfi_tx_oe});
    @(posedge clk);
    #1;
    // Line slot 4 loops to line slot 7 over spare PCM slot 0
    prog(8'h84, 8'h80, 8'h71);
    prog(8'h07, 8'h80, 8'h71);
    prog(8'h80, 8'h00, OP_TRISTATE);
    settle();
    look(4'h0, 4'h2);
    chk("pcm_tx_oe s0", 8'h00, pcm_tx_oe);
    look(4'h7, 4'h3);
    chk("cfi_tx_data s7", 8'h54, cfi_tx_data);
    chk("cfi_tx_oe s7", 8'h01, {7'h0, cfi_tx_oe});
    prog(8'h80, 8'h0F, OP_TRISTATE);
    settle();
    look(4'h0, 4'h2);
    chk("pcm_tx_oe s0", 8'hFF, pcm_tx_oe);
    chk("pcm_tx_data s0", 8'h54, pcm_tx_data);
    // PCM slot 13 loops to PCM slot 5 over spare line slot 9
    prog(8'h09, 8'h0D, 8'h70);
    prog(8'h89, 8'h05, 8'h71);
    prog(8'h85, 8'h0F, OP_TRISTATE);
    settle();
    look(4'h5, 4'h2);
    chk("pcm_tx_data s5", 8'hAD, pcm_tx_data);
    chk("pcm_tx_oe s5", 8'hFF, pcm_tx_oe);
    look(4'h9, 4'h3);
    chk("cfi_tx_oe s9", 8'h00, {7'h0, cfi_tx_oe});
    // Assigned codes 1 to 7 also drive the line output
    for (int c = 1; c < 8; c++) begin
      prog(8'h09, 8'h0D, {OP_CM_HI, c[3:0]});
      settle();
      look(4'h9, 4'h3);
      chk("cfi_tx_oe s9", 8'h01, {7'h0, cfi_tx_oe});
      chk("cfi_tx_data s9", 8'hAD, cfi_tx_data);
    end
    // Back to back controls must stall, yet lose nothing
    @(posedge clk);
    #1;
    stalls = 0;
    send(SEL_DATA, 8'h05);
    send(SEL_ADDR, 8'h85);
    repeat (4) send(SEL_CTRL, OP_TRISTATE);
    host_valid = 1'b0;
    settle();
    chk("stall seen", 8'h01, {7'h0, stalls != 0});
    look(4'h5, 4'h2);
    chk("pcm_tx_oe s5", 8'h33, pcm_tx_oe);
    chk("cmd_error", 8'h00, {7'h0, cmd_error});
    // Unknown control code changes nothing and flags
    prog(8'h85, 8'h0F, 8'h50);
    settle();
    look(4'h5, 4'h2);
    chk("pcm_tx_oe s5", 8'h33, pcm_tx_oe);
    chk("cmd_error", 8'h01, {7'h0, cmd_error});
    // Reset in mid-run tears every loop down
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    settle();
    look(4'h5, 4'h2);
    chk("pcm_tx_oe s5", 8'h00, pcm_tx_oe);
    chk("cmd_error", 8'h00, {7'h0, cmd_error});
    @(posedge clk);
    #1;
    send(2'h3, 8'h00);
    host_valid = 1'b0;
    settle();
    chk("cmd_error", 8'h01, {7'h0, cmd_error});
    finish_test();
  end
endmodule
